// File: pkg/acr_conv_if.sv
// Purpose: carrier between register file and conversion sequencer.
// Assumes: single clock.
// Notes: start is a one-cycle pulse, busy a level.
`timescale 1ns/100ps
interface acr_conv_if;
    logic start;
    logic busy;
    logic done;
    logic [2:0] chan;
    modport regs (output start, output chan, input busy, input done);
    modport engine (input start, input chan, output busy, output done);
endinterface : acr_conv_if

// File: pkg/acr_pkg.sv
// Purpose: shared types for the converter control register block.
// Assumes: nothing beyond the register header.
// Notes: the engine state type is used only by the sequencer; top imports the package but does not use it.
package acr_pkg;
    typedef enum logic [1:0] {ACR_IDLE, ACR_CONVERT, ACR_DONE} acr_state_t;
    typedef logic [2:0] acr_chan_t;
endpackage : acr_pkg

// File: pkg/acr_regs.svh
// Purpose: offsets, field positions, reset values and timing counts for the
//          converter control register block.
// Assumes: 32-bit apb data, one register per aligned word.
// Notes: reserved bits 6 and 3 are stored as written.
// How it works
// - writing one to start bit launches a conversion on the selected input
// - start bit reads one while converting, zero when idle
// - writing zero to start bit changes nothing, never aborts
// - reference-enable bit one turns on internal reference, zero allows external
// - converter-enable bit zero keeps converter off for low power, one enables; a start still runs the sequencer while it is zero
// - three-bit channel field code n selects analog input n
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
`define ACR_CTL0_OFFSET 12'hf70
`define ACR_STATUS_OFFSET 12'hf74
`define ACR_CTL0_RESET 8'h00
`define ACR_START_BIT 7
`define ACR_RSV6_BIT 6
`define ACR_REF_ENABLE_BIT 5
`define ACR_CONVEN_BIT 4
`define ACR_RSV3_BIT 3
`define ACR_CHAN_LSB 0
`define ACR_CHAN_MSB 2
`define ACR_CONV_CYCLES 16
`endif

// File: rtl/acr_conv_seq.sv
// Purpose: conversion sequencer that times one conversion.
// Assumes: start only taken when idle.
// Notes: fixed duration stands in for the analog engine.
`timescale 1ns/100ps
`include "acr_regs.svh"
module acr_conv_seq
    import acr_pkg::*;
#(
    parameter int CONV_CYCLES = `ACR_CONV_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    acr_conv_if.engine cif,
    output logic [2:0] conv_channel
);
    acr_state_t state_r;
    logic [15:0] cnt_r;

    // idle, convert for a fixed count, then flag completion
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_r <= ACR_IDLE;
            cnt_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                ACR_IDLE:
                begin
                    if (cif.start)
                    begin
                        state_r <= ACR_CONVERT;
                        cnt_r <= 16'(CONV_CYCLES - 1);
                    end
                end
                ACR_CONVERT:
                begin
                    if (cnt_r == 16'h0000)
                        state_r <= ACR_DONE;
                    else
                        cnt_r <= cnt_r - 16'h0001;
                end
                ACR_DONE:
                    state_r <= ACR_IDLE;
                default:
                    state_r <= ACR_IDLE;
            endcase
        end
    end

    // latch the selected input at launch
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            conv_channel <= 3'h0;
        else if (state_r == ACR_IDLE && cif.start)
            conv_channel <= cif.chan;
    end

    assign cif.busy = (state_r != ACR_IDLE);
    assign cif.done = (state_r == ACR_DONE);
endmodule : acr_conv_seq

// File: rtl/acr_top.sv
// Purpose: converter control register zero with apb slave and sequencer.
//          one control byte at 0xf70, launch channel readable at 0xf74.
// Assumes: apb3 master, zero wait states.
//          software writes zero to the reserved bits.
// Notes: unmapped addresses read zero, no error.
//        a start written while busy is dropped, not queued.
//        read data is loaded in the setup phase and held for the access.
//        the busy bit covers launch pulse, conversion and done cycle.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "acr_regs.svh"
module acr_top
    import acr_pkg::*;
#(
    parameter int CONV_CYCLES = `ACR_CONV_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic internal_reference_enable,
    output logic converter_enable,
    output logic [2:0] analog_channel_select,
    output logic [2:0] conv_channel,
    output logic conv_busy
);
    // sequencer carrier
    acr_conv_if cif ();

    // stored control bits and strobes
    logic rsv6_r;
    logic rsv3_r;
    logic start_r;
    logic start_nxt;
    logic wr_en;
    logic rd_setup;
    logic sel_ctl;
    logic sel_stat;

    // write data split into fields
    logic wr_start;
    logic wr_rsv6;
    logic wr_ref;
    logic wr_conv;
    logic wr_rsv3;
    logic [2:0] wr_chan;

    // read side images
    logic [7:0] ctl_word;
    logic [31:0] rd_ctl;
    logic [31:0] rd_stat;
    logic [31:0] rd_nxt;

    // register decode on the byte address
    assign sel_ctl = (paddr == `ACR_CTL0_OFFSET);
    assign sel_stat = (paddr == `ACR_STATUS_OFFSET);

    // access-phase write strobe and setup-phase read strobe
    assign wr_en = psel && penable && pwrite && sel_ctl;
    assign rd_setup = psel && !penable && !pwrite;

    // every access completes at once, never in error
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // field slices of the write word
    assign wr_start = pwdata[`ACR_START_BIT];
    assign wr_rsv6 = pwdata[`ACR_RSV6_BIT];
    assign wr_ref = pwdata[`ACR_REF_ENABLE_BIT];
    assign wr_conv = pwdata[`ACR_CONVEN_BIT];
    assign wr_rsv3 = pwdata[`ACR_RSV3_BIT];
    assign wr_chan = pwdata[`ACR_CHAN_MSB:`ACR_CHAN_LSB];

    // internal reference enable, bit five
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            internal_reference_enable <= 1'b0;
        end
        else if (wr_en)
        begin
            internal_reference_enable <= wr_ref;
        end
    end

    // converter enable, bit four
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            converter_enable <= 1'b0;
        end
        else if (wr_en)
        begin
            converter_enable <= wr_conv;
        end
    end

    // channel select, bits two to zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            analog_channel_select <= 3'h0;
        end
        else if (wr_en)
        begin
            analog_channel_select <= wr_chan;
        end
    end

    // reserved bit six, kept as written
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rsv6_r <= 1'b0;
        end
        else if (wr_en)
        begin
            rsv6_r <= wr_rsv6;
        end
    end

    // reserved bit three, kept as written
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rsv3_r <= 1'b0;
        end
        else if (wr_en)
        begin
            rsv3_r <= wr_rsv3;
        end
    end

    // launch request: a one starts only when idle, a zero never touches a run
    assign start_nxt = wr_en && wr_start && !cif.busy;

    // one-cycle start pulse towards the sequencer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            start_r <= 1'b0;
        end
        else
        begin
            start_r <= start_nxt;
        end
    end

    // sequencer hookup
    assign cif.start = start_r;
    assign cif.chan = analog_channel_select;

    // busy covers the launch cycle and clears when the sequencer finishes
    assign conv_busy = start_r || cif.busy;

    // control byte image, busy in the start position
    always_comb
    begin
        ctl_word = 8'h00;
        ctl_word[`ACR_START_BIT] = conv_busy;
        ctl_word[`ACR_RSV6_BIT] = rsv6_r;
        ctl_word[`ACR_REF_ENABLE_BIT] = internal_reference_enable;
        ctl_word[`ACR_CONVEN_BIT] = converter_enable;
        ctl_word[`ACR_RSV3_BIT] = rsv3_r;
        ctl_word[`ACR_CHAN_MSB:`ACR_CHAN_LSB] = analog_channel_select;
    end

    // full read words of both registers
    assign rd_ctl = {24'h00_0000, ctl_word};
    assign rd_stat = {29'h000_0000, conv_channel};

    // read word for the addressed register
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (sel_ctl)
        begin
            rd_nxt = rd_ctl;
        end
        else if (sel_stat)
        begin
            rd_nxt = rd_stat;
        end
        else
        begin
            rd_nxt = 32'h0000_0000;
        end
    end

    // read data captured in the setup phase, steady through the access
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_setup)
        begin
            prdata <= rd_nxt;
        end
    end

    // conversion sequencer
    acr_conv_seq #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_seq (
        .sys_clk(sys_clk),
        .reset(reset),
        .cif(cif.engine),
        .conv_channel(conv_channel)
    );
endmodule : acr_top

// File: verification/acr_top_properties.sv
// Purpose: port checks for acr_top
// Assumes: CONV_CYCLES as in the instance
// Notes: control word at 0xf70
`timescale 1ns/100ps
module acr_props #(parameter int CONV_CYCLES = 16)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic internal_reference_enable,
    input wire logic converter_enable,
    input wire logic [2:0] analog_channel_select,
    input wire logic conv_busy
);
    logic w;
    logic rdc;
    logic [7:0] n;
    // control write and read strobes
    assign w = psel && penable && pwrite && paddr == 12'hf70;
    assign rdc = psel && penable && !pwrite && paddr == 12'hf70;
    // busy cycle count
    always_ff @(posedge sys_clk)
        if (reset || !conv_busy) n <= 8'h00;
        else n <= n + 8'h01;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_st; w && pwdata[7] && !conv_busy |=> conv_busy; endproperty
    a_st: assert property (p_st) else $error("start lost");
    property p_rb; rdc |-> prdata[7] == $past(conv_busy); endproperty
    a_rb: assert property (p_rb) else $error("busy read");
    property p_w0; w && !pwdata[7] && conv_busy && n < CONV_CYCLES + 1 |=> conv_busy; endproperty
    a_w0: assert property (p_w0) else $error("abort");
    property p_rf; w |=> internal_reference_enable == $past(pwdata[5]); endproperty
    a_rf: assert property (p_rf) else $error("ref bit");
    property p_ce; w |=> converter_enable == $past(pwdata[4]); endproperty
    a_ce: assert property (p_ce) else $error("enable bit");
    property p_ch; w |=> analog_channel_select == $past(pwdata[2:0]); endproperty
    a_ch: assert property (p_ch) else $error("channel");
    property p_cl; $fell(conv_busy) |-> n == CONV_CYCLES + 2; endproperty
    a_cl: assert property (p_cl) else $error("busy length");
endmodule : acr_props

// File: verification/adc_control_register_zero_test.sv
// Purpose: self-checking bench for acr_top
// Assumes: pready answers, bench waits for it
// Notes: short conversion of 4 cycles
`timescale 1ns/100ps
module adc_control_register_zero_test;
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, ire, ce, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] ch, cch;
    int n_fail, compares, cyc, k;
    `define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
        $display("BAD %0t mismatch", $time); end end
    acr_top #(.CONV_CYCLES(4)) DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_reference_enable(ire), .converter_enable(ce),
        .analog_channel_select(ch), .conv_channel(cch), .conv_busy(busy));
    // clock and hang guard
    initial
    begin
        sys_clk = 0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        if (++cyc > 3000) begin n_fail++; give_verdict(); end
    // apb transfer, one idle edge after
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk) penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        psel <= 0; penable <= 0;
        @(posedge sys_clk);
    endtask : xf
    task automatic t_idle;
        `CHK({ire, ce, ch, busy}, 6'h00)
        xf(0, 12'hf70, 0);
        `CHK(rd, 32'h0)
        $display("t_idle done");
    endtask : t_idle
    task automatic t_fields;
        for (int i = 0; i < 8; i++)
        begin
            xf(1, 12'hf70, {26'h0, i[0], i[1], 1'b0, i[2:0]});
            `CHK({ire, ce, ch}, {i[0], i[1], i[2:0]})
        end
        $display("t_fields done");
    endtask : t_fields
    task automatic t_conv;
        xf(1, 12'hf70, 32'h93);
        `CHK(busy, 1'b1)
        xf(1, 12'hf70, 32'h13);
        `CHK(busy, 1'b1)
        `CHK(cch, 3'h3)
        xf(0, 12'hf70, 0);
        `CHK(rd[7], 1'b1)
        for (k = 0; k < 40 && busy; k++) @(posedge sys_clk);
        xf(0, 12'hf70, 0);
        `CHK(rd, 32'h13)
        xf(0, 12'hf74, 0);
        `CHK(rd, 32'h3)
        $display("t_conv done");
    endtask : t_conv
    task automatic t_map;
        xf(1, 12'hf78, 32'h80);
        `CHK({busy, ce, pslverr}, 3'h2)
        xf(0, 12'hf78, 0);
        `CHK(rd, 32'h0)
        $display("t_map done");
    endtask : t_map
    task automatic t_reset;
        xf(1, 12'hf70, 32'hb7);
        reset <= 1;
        repeat (2) @(posedge sys_clk);
        reset <= 0;
        @(posedge sys_clk);
        `CHK({ire, ce, ch, busy, cch}, 9'h000)
        xf(0, 12'hf70, 0);
        `CHK(rd, 32'h0)
        $display("t_reset done");
    endtask : t_reset
    task automatic give_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // reset, then scenarios
    initial
    begin
        reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        repeat (8) @(posedge sys_clk);
        reset <= 0;
        @(posedge sys_clk);
        t_idle();
        t_fields();
        t_conv();
        t_map();
        t_reset();
        give_verdict();
    end
endmodule : adc_control_register_zero_test
bind acr_top acr_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (.sys_clk(sys_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .internal_reference_enable(internal_reference_enable),
    .converter_enable(converter_enable), .analog_channel_select(analog_channel_select),
    .conv_busy(conv_busy));
